// file: verilog/brsg_cfg.svh
`ifndef BRSG_CFG_SVH
`define BRSG_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define BRSG_CLK_MHZ            25
`define BRSG_FILTER_TIME_NS     100000
`define BRSG_PWRUP_TIME_NS      50000000

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define BRSG_ADDR_RST_CTRL      12'h000
`define BRSG_ADDR_STACK         12'h004
`define BRSG_ADDR_STATUS        12'h008

// ****************************************************************
// Reset control register fields
// ****************************************************************
`define BRSG_BIT_SOFT_EN        6
`define BRSG_BIT_RST_INSTR      4
`define BRSG_BIT_WDT_TIMEOUT    3
`define BRSG_BIT_POWERDOWN      2
`define BRSG_BIT_POWER_ON       1
`define BRSG_BIT_BROWNOUT       0

// ****************************************************************
// Stack register fields and limits
// ****************************************************************
`define BRSG_BIT_STK_FULL       7
`define BRSG_BIT_STK_UNF        6
`define BRSG_SP_MAX             5'h1f
`define BRSG_SP_LAST_FREE       5'h1e

// ****************************************************************
// Brown-out enable encodings
// ****************************************************************
`define BRSG_EN_OFF             2'h0
`define BRSG_EN_SOFT            2'h1
`define BRSG_EN_NOSLEEP         2'h2
`define BRSG_EN_ON              2'h3

// ****************************************************************
// Program counter vectors and reset values
// ****************************************************************
`define BRSG_VEC_RESET          21'h000000
`define BRSG_VEC_HIGH           21'h000008
`define BRSG_VEC_LOW            21'h000018
`define BRSG_PC_STEP            21'h000002
`define BRSG_RST_SOFT_EN        1'h1
`define BRSG_RST_FLAG_SET       1'h1
`define BRSG_RST_FLAG_CLR       1'h0

`endif

// file: verilog/brsg_pkg.sv
package brsg_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_FULL,
        MODE_PM_RUN,
        MODE_IDLE,
        MODE_SLEEP
    } brsg_mode_t;

    typedef enum logic [1:0] {
        BO_ARMED,
        BO_FILTER,
        BO_HELD,
        BO_PWRUP
    } brsg_bo_state_t;

    typedef struct packed {
        logic [1:0] brownout_enable_cfg;
        logic [1:0] brownout_level_cfg;
        logic       powerup_timer_enable;
        logic       stack_fault_reset_enable;
    } brsg_cfg_t;

    typedef struct packed {
        logic watchdog_timeout;
        logic reset_instr;
        logic master_clear_pin;
        logic irq_wake;
        logic high_prio_irq_enable;
        logic low_prio_irq_enable;
        logic push;
        logic pop;
    } brsg_event_t;

endpackage

// file: verilog/brsg_top.sv
// Contract
// - Enabled brown-out filters supply drop, then holds reset until supply recovers.
// - Power-up timer, if enabled, extends reset after supply recovery.
// - Supply drop during power-up timing returns to brown-out and restarts timer.
// - Brown-out enable and power-up timer enable are independent.
// - Software mode: detection active only while soft enable bit set.
// - Soft enable acts only in software mode, otherwise reads zero.
// - Trip level comes only from configuration, never from software.
// - No-sleep mode disables detection in sleep, re-enables in run/idle.
// - Mode 11 always detects; mode 00 never detects.
// - Brown-out flag clears on every brown-out or power-on reset.
// - Power-on and brown-out resets load flags and vector as tabulated.
// - Soft enable resets to one at power-on, kept otherwise only if active.
// - Watchdog timeout in run modes resets to zero, clears timeout flag.
// - Watchdog timeout in idle/sleep wakes at PC+2, clears two flags.
// - Interrupt wake clears powerdown flag; resumes PC+2 or vectors.
// - Stack pointer 0..31, pre-increment push, post-decrement pop, zero at reset.
// - Stack full flag set on 31st push, cleared by software or power-on.
// - With fault reset, 31st push stores PC+2, sets full, resets, pointer zero.
// - Without fault reset, pointer saturates at 31, 31st entry kept.
// - Pop on empty returns zero, sets underflow flag, pointer stays zero.
// - Underflow resets only when fault reset enabled.
// - Software sets power-on flag; brown-out flag zero then means brown-out.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "brsg_cfg.svh"

module brsg_top #(
    parameter int FILTER_CYC =
        (`BRSG_FILTER_TIME_NS * `BRSG_CLK_MHZ + 999) / 1000,
    parameter int PWRUP_CYC  =
        (`BRSG_PWRUP_TIME_NS * `BRSG_CLK_MHZ + 999) / 1000
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire brsg_pkg::brsg_cfg_t   cfg,
    input  wire brsg_pkg::brsg_mode_t  power_mode,
    input  wire brsg_pkg::brsg_event_t core_event,
    input  wire logic [20:0]         core_pc,
    input  wire logic                supply_low_async,
    output logic                     brownout_detect_en,
    output logic      [1:0]          brownout_level,
    output logic                     core_reset,
    output logic                     pc_load,
    output logic      [20:0]         pc_value
);
    import brsg_pkg::*;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic is_run(input brsg_mode_t m);
        return (m == MODE_FULL) || (m == MODE_PM_RUN);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic           low_meta;
    logic           supply_low;
    brsg_bo_state_t bo_state;
    brsg_bo_state_t next_bo_state;
    logic [31:0]    cnt;
    logic [31:0]    next_cnt;
    logic           soft_brownout_enable;
    logic           reset_instr_flag;
    logic           watchdog_timeout_flag;
    logic           powerdown_flag;
    logic           power_on_reset_flag;
    logic           brownout_flag;
    logic           stack_full_flag;
    logic           stack_underflow_flag;
    logic [4:0]     return_stack_pointer;
    logic [20:0]    stk_mem [0:31];
    logic           next_soft_en;
    logic           next_ri;
    logic           next_wdt_flag;
    logic           next_pd;
    logic           next_por;
    logic           next_bor;
    logic           next_full;
    logic           next_unf;
    logic [4:0]     next_sp;
    logic           next_pc_load;
    logic [20:0]    next_pc_value;
    logic [31:0]    reset_control_register_word;
    logic [31:0]    stk_word;
    logic [31:0]    stat_word;

    // ************************************************************
    // Supply comparator synchroniser
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_meta   <= 1'h0;
            supply_low <= 1'h0;
        end else begin
            low_meta   <= supply_low_async;
            supply_low <= low_meta;
        end
    end

    // ************************************************************
    // Detection enable
    // ************************************************************
    wire soft_mode  = cfg.brownout_enable_cfg == `BRSG_EN_SOFT;
    wire always_on  = cfg.brownout_enable_cfg == `BRSG_EN_ON;
    wire no_sleep   = (cfg.brownout_enable_cfg == `BRSG_EN_NOSLEEP)
                      && (power_mode != MODE_SLEEP);
    wire soft_on    = soft_mode && soft_brownout_enable;
    wire bo_enabled = always_on || no_sleep || soft_on;

    wire filt_done  = cnt == 32'(FILTER_CYC - 1);
    wire pwrup_done = cnt == 32'(PWRUP_CYC - 1);
    wire bo_trip    = (bo_state == BO_FILTER) && bo_enabled
                      && supply_low && filt_done;
    wire live       = (bo_state == BO_ARMED) || (bo_state == BO_FILTER);

    // ************************************************************
    // Brown-out and power-up timer sequencing
    // ************************************************************
    always_comb begin
        next_bo_state = bo_state;
        next_cnt      = cnt + 32'h1;
        case (bo_state)
            BO_ARMED: begin
                next_cnt = 32'h0;
                if (bo_enabled && supply_low) begin
                    next_bo_state = BO_FILTER;
                end
            end
            BO_FILTER: begin
                if (!bo_enabled || !supply_low) begin
                    next_bo_state = BO_ARMED;
                    next_cnt      = 32'h0;
                end else if (filt_done) begin
                    next_bo_state = BO_HELD;
                    next_cnt      = 32'h0;
                end
            end
            BO_HELD: begin
                next_cnt = 32'h0;
                if (!supply_low) begin
                    next_bo_state = cfg.powerup_timer_enable ?
                                    BO_PWRUP : BO_ARMED;
                end
            end
            BO_PWRUP: begin
                if (supply_low && bo_enabled) begin
                    next_bo_state = BO_HELD;
                    next_cnt      = 32'h0;
                end else if (!cfg.powerup_timer_enable || pwrup_done) begin
                    next_bo_state = BO_ARMED;
                    next_cnt      = 32'h0;
                end
            end
            default: begin
                next_bo_state = BO_ARMED;
                next_cnt      = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bo_state <= BO_PWRUP;
            cnt      <= 32'h0;
        end else begin
            bo_state <= next_bo_state;
            cnt      <= next_cnt;
        end
    end

    // ************************************************************
    // Core events
    // ************************************************************
    wire in_run      = is_run(power_mode);
    wire wdt_reset   = live && core_event.watchdog_timeout && in_run;
    wire wdt_wake    = live && core_event.watchdog_timeout && !in_run;
    wire irq_wake    = live && core_event.irq_wake && !in_run;
    wire instr_reset = live && core_event.reset_instr;
    wire master_clear_pin_reset  = live && core_event.master_clear_pin;
    wire push        = live && core_event.push;
    wire pop         = live && core_event.pop && !core_event.push;
    wire sp_empty    = return_stack_pointer == 5'h0;
    wire full_hit    = push
                       && (return_stack_pointer >= `BRSG_SP_LAST_FREE);
    wire under_pop   = pop && sp_empty;
    wire stack_reset = cfg.stack_fault_reset_enable
                       && (full_hit || under_pop);
    wire any_reset   = bo_trip || wdt_reset || instr_reset
                       || master_clear_pin_reset || stack_reset;
    wire [4:0]  sp_inc  = 5'(return_stack_pointer + 5'h1);
    wire [4:0]  sp_dec  = 5'(return_stack_pointer - 5'h1);
    wire [20:0] pc_next = 21'(core_pc + `BRSG_PC_STEP);

    // ************************************************************
    // APB decode
    // ************************************************************
    wire apb_setup = psel && !penable;
    wire apb_wr    = psel && penable && pready && pwrite;
    wire hit_reset_control_register  = paddr == `BRSG_ADDR_RST_CTRL;
    wire hit_stk   = paddr == `BRSG_ADDR_STACK;
    wire hit_stat  = paddr == `BRSG_ADDR_STATUS;
    wire mapped    = hit_reset_control_register || hit_stk || hit_stat;
    wire wr_reset_control_register   = apb_wr && hit_reset_control_register;
    wire wr_stk    = apb_wr && hit_stk;
    wire [31:0] rd_word = hit_reset_control_register ? reset_control_register_word :
                          hit_stk  ? stk_word  :
                          hit_stat ? stat_word : 32'h0;

    always_comb begin
        reset_control_register_word = 32'h0;
        reset_control_register_word[`BRSG_BIT_SOFT_EN]     = soft_on;
        reset_control_register_word[`BRSG_BIT_RST_INSTR]   = reset_instr_flag;
        reset_control_register_word[`BRSG_BIT_WDT_TIMEOUT] = watchdog_timeout_flag;
        reset_control_register_word[`BRSG_BIT_POWERDOWN]   = powerdown_flag;
        reset_control_register_word[`BRSG_BIT_POWER_ON]    = power_on_reset_flag;
        reset_control_register_word[`BRSG_BIT_BROWNOUT]    = brownout_flag;
        stk_word = {27'h0, return_stack_pointer};
        stk_word[`BRSG_BIT_STK_FULL]     = stack_full_flag;
        stk_word[`BRSG_BIT_STK_UNF]      = stack_underflow_flag;
        stat_word = {24'h0, 2'h0, supply_low, bo_enabled,
                     2'(bo_state), cfg.brownout_level_cfg};
    end

    // ************************************************************
    // Reset-cause flags and soft enable
    // ************************************************************
    always_comb begin
        next_soft_en  = soft_brownout_enable;
        next_ri       = reset_instr_flag;
        next_wdt_flag = watchdog_timeout_flag;
        next_pd       = powerdown_flag;
        next_por      = power_on_reset_flag;
        next_bor      = brownout_flag;
        if (wr_reset_control_register) begin
            if (soft_mode) begin
                next_soft_en = pwdata[`BRSG_BIT_SOFT_EN];
            end
            next_ri  = pwdata[`BRSG_BIT_RST_INSTR];
            next_por = pwdata[`BRSG_BIT_POWER_ON];
            next_bor = pwdata[`BRSG_BIT_BROWNOUT];
        end
        if (instr_reset) begin
            next_ri = 1'h0;
        end
        if (master_clear_pin_reset && power_mode != MODE_FULL) begin
            next_wdt_flag = 1'h1;
        end
        if (master_clear_pin_reset && !in_run) begin
            next_pd = 1'h0;
        end
        if (wdt_reset || wdt_wake) begin
            next_wdt_flag = 1'h0;
        end
        if (wdt_wake || irq_wake) begin
            next_pd = 1'h0;
        end
        if (bo_trip) begin
            next_ri       = 1'h1;
            next_wdt_flag = 1'h1;
            next_pd       = 1'h1;
            next_bor      = 1'h0;
        end
        if (any_reset) begin
            next_soft_en = soft_on;
        end
    end

    // ************************************************************
    // Stack pointer and flags
    // ************************************************************
    always_comb begin
        next_sp   = return_stack_pointer;
        next_full = stack_full_flag;
        next_unf  = stack_underflow_flag;
        if (wr_stk) begin
            next_sp   = pwdata[4:0];
            next_full = stack_full_flag && pwdata[`BRSG_BIT_STK_FULL];
            next_unf  = stack_underflow_flag && pwdata[`BRSG_BIT_STK_UNF];
        end
        if (push) begin
            next_sp = full_hit ? `BRSG_SP_MAX : sp_inc;
        end else if (pop) begin
            next_sp = sp_empty ? 5'h0 : sp_dec;
        end
        if (full_hit) begin
            next_full = 1'h1;
        end
        if (under_pop) begin
            next_unf = 1'h1;
        end
        if (any_reset) begin
            next_sp = 5'h0;
        end
    end

    // ************************************************************
    // Program counter load
    // ************************************************************
    always_comb begin
        next_pc_load  = any_reset || wdt_wake || irq_wake || pop;
        next_pc_value = `BRSG_VEC_RESET;
        if (any_reset) begin
            next_pc_value = `BRSG_VEC_RESET;
        end else if (wdt_wake) begin
            next_pc_value = pc_next;
        end else if (irq_wake) begin
            next_pc_value = core_event.high_prio_irq_enable ?
                            `BRSG_VEC_HIGH :
                            core_event.low_prio_irq_enable ?
                            `BRSG_VEC_LOW : pc_next;
        end else if (pop && !sp_empty) begin
            next_pc_value = stk_mem[return_stack_pointer];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_brownout_enable  <= `BRSG_RST_SOFT_EN;
            reset_instr_flag      <= `BRSG_RST_FLAG_SET;
            watchdog_timeout_flag <= `BRSG_RST_FLAG_SET;
            powerdown_flag        <= `BRSG_RST_FLAG_SET;
            power_on_reset_flag   <= `BRSG_RST_FLAG_CLR;
            brownout_flag         <= `BRSG_RST_FLAG_CLR;
            stack_full_flag       <= `BRSG_RST_FLAG_CLR;
            stack_underflow_flag  <= `BRSG_RST_FLAG_CLR;
            return_stack_pointer  <= 5'h0;
        end else begin
            soft_brownout_enable  <= next_soft_en;
            reset_instr_flag      <= next_ri;
            watchdog_timeout_flag <= next_wdt_flag;
            powerdown_flag        <= next_pd;
            power_on_reset_flag   <= next_por;
            brownout_flag         <= next_bor;
            stack_full_flag       <= next_full;
            stack_underflow_flag  <= next_unf;
            return_stack_pointer  <= next_sp;
        end
    end

    always_ff @(posedge clk) begin
        if (push && return_stack_pointer != `BRSG_SP_MAX) begin
            stk_mem[sp_inc] <= pc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_reset         <= 1'h1;
            pc_load            <= 1'h0;
            pc_value           <= `BRSG_VEC_RESET;
            brownout_detect_en <= 1'h0;
            brownout_level     <= 2'h0;
        end else begin
            core_reset         <= any_reset || (next_bo_state == BO_HELD)
                                  || (next_bo_state == BO_PWRUP);
            pc_load            <= next_pc_load;
            pc_value           <= next_pc_value;
            brownout_detect_en <= bo_enabled;
            brownout_level     <= cfg.brownout_level_cfg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !mapped;
            prdata  <= (apb_setup && !pwrite) ? rd_word : 32'h0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    filter_trip_a: assert property (bo_trip |=> core_reset
        && bo_state == BO_HELD) else $error("trip did not hold reset");
    held_low_a: assert property (bo_state == BO_HELD && supply_low
        |=> bo_state == BO_HELD && core_reset)
        else $error("reset released while supply low");
    pwrup_start_a: assert property (bo_state == BO_HELD && !supply_low
        && cfg.powerup_timer_enable |=> bo_state == BO_PWRUP && core_reset)
        else $error("power-up timer not started");
    pwrup_abort_a: assert property (bo_state == BO_PWRUP && supply_low
        && bo_enabled |=> bo_state == BO_HELD ##1 cnt == 32'h0)
        else $error("power-up timer not reinitialised");
    soft_gate_a: assert property (soft_mode && !soft_brownout_enable
        |-> !bo_enabled) else $error("soft disable ignored");
    sleep_gate_a: assert property (
        cfg.brownout_enable_cfg == `BRSG_EN_NOSLEEP
        |-> bo_enabled == (power_mode != MODE_SLEEP))
        else $error("sleep gating wrong");
    soft_read_a: assert property (apb_setup && !pwrite && hit_reset_control_register
        && !soft_mode |=> !prdata[`BRSG_BIT_SOFT_EN])
        else $error("soft enable read not zero");
    bor_flags_a: assert property (bo_trip |=> !brownout_flag
        && reset_instr_flag && watchdog_timeout_flag && powerdown_flag)
        else $error("brown-out flags wrong");
    wdt_run_a: assert property (wdt_reset |=> pc_load
        && pc_value == `BRSG_VEC_RESET && !watchdog_timeout_flag
        && core_reset) else $error("watchdog reset wrong");
    wdt_wake_a: assert property (wdt_wake && !any_reset |=> pc_load
        && !core_reset && !watchdog_timeout_flag && !powerdown_flag
        && pc_value == $past(pc_next)) else $error("watchdog wake wrong");
    sp_sat_a: assert property (push && return_stack_pointer ==
        `BRSG_SP_MAX && !cfg.stack_fault_reset_enable && !any_reset
        |=> return_stack_pointer == `BRSG_SP_MAX && stack_full_flag)
        else $error("stack pointer left 31");
    full_reset_a: assert property (full_hit
        && cfg.stack_fault_reset_enable |=> core_reset
        && stack_full_flag && return_stack_pointer == 5'h0)
        else $error("stack full reset wrong");
    underflow_a: assert property (under_pop && !any_reset |=>
        pc_value == `BRSG_VEC_RESET && stack_underflow_flag
        && return_stack_pointer == 5'h0 && !core_reset)
        else $error("underflow handling wrong");

    trip_c: cover property (bo_trip ##[1:1000] bo_state == BO_PWRUP);
    full_c: cover property (full_hit && !cfg.stack_fault_reset_enable);
    under_c: cover property (under_pop);
    irq_c: cover property (irq_wake && core_event.high_prio_irq_enable);

endmodule // brsg_top

// file: verif/brsg_core_model.sv
`timescale 1ns/1ps
// Core side: takes reloads, steps the PC while running
module brsg_core_model (
    input  wire logic        clk,
    input  wire logic        core_reset,
    input  wire logic        pc_load,
    input  wire logic [20:0] pc_value,
    output logic      [20:0] core_pc
);
    initial core_pc = 21'h000100;
    always @(posedge clk) begin
        if (pc_load) begin
            core_pc <= pc_value;
        end else if (!core_reset) begin
            core_pc <= core_pc + 21'h000002;
        end
    end
endmodule // brsg_core_model

// file: verif/tb_brsg_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_brsg_top;
    import brsg_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sl;
    logic bde, core_reset, pc_load, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  lvl;
    logic [20:0] pc_value, core_pc, p0;
    brsg_cfg_t   cfg;
    brsg_mode_t  pm;
    brsg_event_t ev;
    int mismatches, num_checks;
    brsg_top #(.FILTER_CYC(8), .PWRUP_CYC(20)) u_brsg_top (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .power_mode(pm), .core_event(ev),
        .core_pc(core_pc), .supply_low_async(sl), .brownout_detect_en(bde),
        .brownout_level(lvl), .core_reset(core_reset), .pc_load(pc_load),
        .pc_value(pc_value));
    brsg_core_model u_brsg_core_model (.clk(clk), .core_reset(core_reset),
        .pc_load(pc_load), .pc_value(pc_value), .core_pc(core_pc));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge clk);
        ev <= brsg_event_t'(e);
        #1 p0 = core_pc;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask
    task automatic wait_run(input logic lvl_want);
        for (int i = 0; i < 60 && core_reset !== lvl_want; i++) @(posedge clk);
        `CHK("reset level", lvl_want, core_reset)
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_stack;
        logic [20:0] pp;
        pulse(8'h02);
        pp = p0;
        apb(1'b0, 12'h004, 32'h0); `CHK("ptr", 32'h01, r)
        pulse(8'h01); `CHK("pop", 21'(pp + 21'h2), pc_value)
        `CHK("pop load", 1'b1, pc_load)
        pulse(8'h01); `CHK("unf pc", 21'h0, pc_value)
        `CHK("unf rst", 1'b0, core_reset)
        apb(1'b0, 12'h004, 32'h0); `CHK("unf flag", 32'h40, r)
        repeat (32) pulse(8'h02);
        apb(1'b0, 12'h004, 32'h0); `CHK("full", 32'hdf, r)
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0); `CHK("stk clr", 32'h0, r)
        cfg.stack_fault_reset_enable <= 1'b1;
        pulse(8'h01); `CHK("unf reset", 1'b1, core_reset)
    endtask
    task automatic t_wdt;
        pulse(8'h80); `CHK("wdt rst", 1'b1, core_reset)
        `CHK("wdt pc", 21'h0, pc_value)
        apb(1'b0, 12'h000, 32'h0); `CHK("wdt flags", 32'h54, r)
    endtask
    task automatic t_wake;
        pm <= MODE_SLEEP;
        pulse(8'h80); `CHK("wake pc", 21'(p0 + 21'h2), pc_value)
        `CHK("wake rst", 1'b0, core_reset)
        pulse(8'h18); `CHK("irq vec", 21'h8, pc_value)
        apb(1'b0, 12'h000, 32'h0); `CHK("wake flags", 32'h50, r)
        pm <= MODE_FULL;
    endtask
    task automatic t_por;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(1'b0);
        apb(1'b0, 12'h000, 32'h0); `CHK("por again", 32'h5c, r)
        apb(1'b0, 12'h004, 32'h0); `CHK("por stack", 32'h0, r)
    endtask
    task automatic t_bo;
        `CHK("detect en", 1'b1, bde)
        apb(1'b1, 12'h000, 32'h12);
        repeat (2) @(posedge clk);
        `CHK("soft off", 1'b0, bde)
        apb(1'b1, 12'h000, 32'h52);
        sl <= 1'b1;
        wait_run(1'b1);
        apb(1'b0, 12'h000, 32'h0); `CHK("bo flags", 32'h5e, r)
        sl <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("pwrup hold", 1'b1, core_reset)
        wait_run(1'b0); `CHK("pwrup end", 1'b0, core_reset)
    endtask
    initial begin
        rst_n <= 1'b0; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
        paddr <= '0; pwdata <= '0; sl <= 1'b0; ev <= '0; pm <= MODE_FULL;
        cfg <= '{2'h1, 2'h2, 1'b1, 1'b0};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(1'b0);
        apb(1'b0, 12'h000, 32'h0); `CHK("por flags", 32'h5c, r)
        `CHK("level", 2'h2, lvl)
        apb(1'b0, 12'h00c, 32'h0); `CHK("unmapped", 1'b1, err)
        t_stack();
        t_wdt();
        t_wake();
        t_bo();
        t_por();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule // tb_brsg_top
